/* rtl/reference_search_homing.v */
`timescale 1ns/1ps
`include "homing_defs.vh"


module reference_search_homing (
	input wire core_clk,
	input wire rst_n,
	input wire cmd_valid,
	input wire [7:0] cmd_opcode,
	input wire [1:0] cmd_type,
	output reg rsp_valid_q,
	output reg rsp_error_q,
	output reg rsp_busy_q,
	input wire [7:0] homing_mode,
	input wire signed [11:0] host_velocity,
	input wire [10:0] search_speed,
	input wire [10:0] calib_speed,
	input wire [10:0] accel,
	input wire [3:0] pulse_div,
	input wire [3:0] ramp_div,
	input wire [3:0] mres,
	input wire pos_mode,
	input wire stop_left_en,
	input wire stop_right_en,
	input wire left_sw_pin,
	input wire right_sw_pin,
	input wire home_sw_pin,
	output wire step_pulse,
	output wire step_dir,
	output wire fullstep_pulse,
	output reg signed [31:0] actual_position_q,
	output reg [31:0] switch_distance_q,
	output reg search_busy_q
);

	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function signed [11:0] sat_vel;
		input signed [12:0] v;
		begin
			if (v > $signed({1'b0, `VEL_MAX}))
				sat_vel = `VEL_MAX;
			else if (v < -$signed({1'b0, `VEL_MAX}))
				sat_vel = -`VEL_MAX;
			else
				sat_vel = v[11:0];
		end
	endfunction

	function signed [11:0] dir_speed;
		input dir;
		input [10:0] spd;
		begin
			dir_speed = dir ? sat_vel({2'b00, spd}) : sat_vel(-$signed({2'b00, spd}));
		end
	endfunction

	// ---------------------------------------------
	// Switch input synchronisers
	// ---------------------------------------------
	reg [2:0] sw_meta_q;
	reg [2:0] sw_sync_q;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_meta_q <= 3'h0;
			sw_sync_q <= 3'h0;
		end else begin
			sw_meta_q <= {home_sw_pin, right_sw_pin, left_sw_pin};
			sw_sync_q <= sw_meta_q;
		end
	end

	wire left_s;
	wire right_s;
	wire home_s;

	assign left_s = sw_sync_q[0];
	assign right_s = sw_sync_q[1];
	assign home_s = sw_sync_q[2];

	// ---------------------------------------------
	// 16 MHz reference tick from the core clock
	// ---------------------------------------------
	reg [4:0] ref_acc_q;
	reg ref_tick_q;
	wire [5:0] ref_sum;
	wire [5:0] ref_wrap;

	assign ref_sum = {1'b0, ref_acc_q} + {1'b0, `REF_CLK_MHZ};
	assign ref_wrap = ref_sum - {1'b0, `CORE_CLK_MHZ};

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_acc_q <= 5'h0;
			ref_tick_q <= 1'b0;
		end else if (ref_sum >= {1'b0, `CORE_CLK_MHZ}) begin
			ref_acc_q <= ref_wrap[4:0];
			ref_tick_q <= 1'b1;
		end else begin
			ref_acc_q <= ref_sum[4:0];
			ref_tick_q <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Mode decode
	// ---------------------------------------------
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [7:0] mode_q;
	reg dir_q;
	reg dir_d;
	reg signed [31:0] p_far_q;
	reg signed [31:0] p_a_q;
	reg signed [31:0] p_b_q;
	reg signed [31:0] p_far_d;
	reg signed [31:0] p_a_d;
	reg signed [31:0] p_b_d;

	wire [5:0] cmd_base;
	wire cmd_mode_ok;
	wire [5:0] base;
	wire side_left;
	wire home_mode;
	wire two_side;
	wire far_mode;
	wire ref_act;
	wire far_act;

	assign cmd_base = homing_mode[`MODE_BASE_MSB:0];
	assign cmd_mode_ok = (cmd_base >= `MODE_LEFT_ONLY) && (cmd_base <= `MODE_HOME_NEG);
	assign base = mode_q[`MODE_BASE_MSB:0];
	assign side_left = ~mode_q[`MODE_SWAP_BIT];
	assign home_mode = base >= `MODE_HOME_NEG_REV;
	assign two_side = (base == `MODE_RIGHT_LEFT_MID) || (base == `MODE_LEFT_MID) ||
		(base == `MODE_HOME_POS) || (base == `MODE_HOME_NEG);
	assign far_mode = (base == `MODE_RIGHT_LEFT) || (base == `MODE_RIGHT_LEFT_MID);
	assign ref_act = home_mode ? (home_s ^ mode_q[`MODE_INVERT_BIT]) :
		(side_left ? left_s : right_s);
	assign far_act = side_left ? right_s : left_s;

	// ---------------------------------------------
	// Command decode
	// ---------------------------------------------
	wire cmd_hit;
	wire cmd_start;
	wire cmd_stop;

	assign cmd_hit = cmd_valid && (cmd_opcode == `REF_SEARCH_OPCODE);
	assign cmd_start = cmd_hit && (cmd_type == `CMD_START) && cmd_mode_ok && !search_busy_q;
	assign cmd_stop = cmd_hit && (cmd_type == `CMD_STOP);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_q <= 1'b0;
			rsp_error_q <= 1'b0;
			rsp_busy_q <= 1'b0;
		end else begin
			rsp_valid_q <= cmd_hit;
			rsp_error_q <= cmd_hit && ((cmd_type > `CMD_STATUS) ||
				((cmd_type == `CMD_START) && !cmd_mode_ok));
			rsp_busy_q <= search_busy_q || cmd_start;
		end
	end

	// ---------------------------------------------
	// Motion units
	// ---------------------------------------------
	wire signed [11:0] vel;
	reg signed [11:0] target;

	accel_ramp u_ramp (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ref_tick(ref_tick_q),
		.target(target),
		.accel(accel),
		.ramp_div(ramp_div),
		.pulse_div(pulse_div),
		.pos_mode(pos_mode && !search_busy_q),
		.vel_q(vel)
	);

	step_rate_gen u_step (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ref_tick(ref_tick_q),
		.vel(vel),
		.pulse_div(pulse_div),
		.mres(mres),
		.step_pulse_q(step_pulse),
		.step_dir_q(step_dir),
		.fullstep_pulse_q(fullstep_pulse)
	);

	// ---------------------------------------------
	// Target velocity
	// ---------------------------------------------
	always @* begin
		target = 12'sh0;
		case (state_q)
			`ST_IDLE: begin
				target = sat_vel({host_velocity[11], host_velocity});
				if (stop_left_en && left_s && host_velocity < 12'sh0)
					target = 12'sh0;
				if (stop_right_en && right_s && host_velocity > 12'sh0)
					target = 12'sh0;
			end
			`ST_SEEK_FAR: target = dir_speed(dir_q, search_speed);
			`ST_SEEK: target = dir_speed(dir_q, search_speed);
			`ST_THROUGH: target = dir_speed(dir_q, calib_speed);
			`ST_BACKOFF: target = dir_speed(~dir_q, calib_speed);
			`ST_REENTER: target = dir_speed(dir_q ^ two_side, calib_speed);
			default: target = 12'sh0;
		endcase
	end

	// ---------------------------------------------
	// Homing sequencer
	// ---------------------------------------------
	wire signed [32:0] mid_sum;
	wire signed [31:0] mid;
	wire signed [31:0] far_dist;
	wire rebase;

	assign mid_sum = {p_a_q[31], p_a_q} + {p_b_q[31], p_b_q};
	assign mid = mid_sum[32:1];
	assign far_dist = p_far_q - mid;
	assign rebase = (state_q == `ST_HALT) && (vel == 12'sh0);

	always @* begin
		state_d = state_q;
		dir_d = dir_q;
		p_far_d = p_far_q;
		p_a_d = p_a_q;
		p_b_d = p_b_q;
		case (state_q)
			`ST_IDLE: begin
			end
			`ST_SEEK_FAR: begin
				if (far_act) begin
					p_far_d = actual_position_q;
					dir_d = ~side_left;
					state_d = `ST_SEEK;
				end
			end
			`ST_SEEK: begin
				if (ref_act) begin
					p_a_d = actual_position_q;
					state_d = two_side ? `ST_THROUGH : `ST_BACKOFF;
				end else if (base == `MODE_HOME_NEG_REV && left_s) begin
					dir_d = 1'b1;
				end else if (base == `MODE_HOME_POS_REV && right_s) begin
					dir_d = 1'b0;
				end
			end
			`ST_THROUGH: begin
				if (!ref_act)
					state_d = `ST_REENTER;
			end
			`ST_BACKOFF: begin
				if (!ref_act) begin
					p_a_d = actual_position_q;
					state_d = `ST_REENTER;
				end
			end
			`ST_REENTER: begin
				if (ref_act) begin
					p_b_d = actual_position_q;
					state_d = `ST_HALT;
				end
			end
			`ST_HALT: begin
				if (rebase)
					state_d = `ST_IDLE;
			end
			`ST_ABORT: begin
				if (vel == 12'sh0)
					state_d = `ST_IDLE;
			end
			default: state_d = `ST_IDLE;
		endcase
		if (cmd_stop && state_q != `ST_IDLE && state_q != `ST_ABORT)
			state_d = `ST_ABORT;
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= `ST_IDLE;
			mode_q <= 8'h0;
			dir_q <= 1'b0;
			p_far_q <= 32'sh0;
			p_a_q <= 32'sh0;
			p_b_q <= 32'sh0;
			search_busy_q <= 1'b0;
			switch_distance_q <= 32'h0;
		end else if (cmd_start) begin
			mode_q <= homing_mode;
			search_busy_q <= 1'b1;
			case (cmd_base)
				`MODE_RIGHT_LEFT, `MODE_RIGHT_LEFT_MID: begin
					state_q <= `ST_SEEK_FAR;
					dir_q <= ~homing_mode[`MODE_SWAP_BIT];
				end
				`MODE_LEFT_ONLY, `MODE_LEFT_MID: begin
					state_q <= `ST_SEEK;
					dir_q <= homing_mode[`MODE_SWAP_BIT];
				end
				`MODE_HOME_POS_REV, `MODE_HOME_POS: begin
					state_q <= `ST_SEEK;
					dir_q <= 1'b1;
				end
				default: begin
					state_q <= `ST_SEEK;
					dir_q <= 1'b0;
				end
			endcase
		end else begin
			state_q <= state_d;
			dir_q <= dir_d;
			p_far_q <= p_far_d;
			p_a_q <= p_a_d;
			p_b_q <= p_b_d;
			if (state_d == `ST_IDLE)
				search_busy_q <= 1'b0;
			if (rebase && far_mode)
				switch_distance_q <= far_dist[31] ? -far_dist : far_dist;
		end
	end

	// ---------------------------------------------
	// Actual position
	// ---------------------------------------------
	wire signed [31:0] step_delta;

	assign step_delta = !step_pulse ? 32'sh0 : (step_dir ? 32'sh1 : -32'sh1);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			actual_position_q <= 32'sh0;
		else if (rebase)
			actual_position_q <= actual_position_q + step_delta - mid;
		else
			actual_position_q <= actual_position_q + step_delta;
	end

endmodule

/* rtl/homing_defs.vh */
`ifndef HOMING_DEFS_VH
`define HOMING_DEFS_VH

// ---------------------------------------------
// Command interface
// ---------------------------------------------
`define REF_SEARCH_OPCODE 8'h0d
`define CMD_START 2'h0
`define CMD_STOP 2'h1
`define CMD_STATUS 2'h2

// ---------------------------------------------
// Homing mode field
// ---------------------------------------------
`define MODE_BASE_MSB 5
`define MODE_SWAP_BIT 6
`define MODE_INVERT_BIT 7
`define MODE_LEFT_ONLY 6'h01
`define MODE_RIGHT_LEFT 6'h02
`define MODE_RIGHT_LEFT_MID 6'h03
`define MODE_LEFT_MID 6'h04
`define MODE_HOME_NEG_REV 6'h05
`define MODE_HOME_POS_REV 6'h06
`define MODE_HOME_POS 6'h07
`define MODE_HOME_NEG 6'h08

// ---------------------------------------------
// Unit conversion
// ---------------------------------------------
`define VEL_MAX 12'sh7ff
`define ACC_MAX 11'h7ff
`define DIV_MAX 4'hd
`define MRES_MAX 4'h8
`define VEL_SHIFT 5'h10
`define ACC_SHIFT 5'h0d
`define ACC_WINDOW 5'h0c
`define REF_CLK_MHZ 5'h10
`define CORE_CLK_MHZ 5'h19

// ---------------------------------------------
// Homing sequencer states
// ---------------------------------------------
`define ST_IDLE 3'h0
`define ST_SEEK_FAR 3'h1
`define ST_SEEK 3'h2
`define ST_THROUGH 3'h3
`define ST_BACKOFF 3'h4
`define ST_REENTER 3'h5
`define ST_HALT 3'h6
`define ST_ABORT 3'h7

`endif

/* rtl/step_rate_gen.v */
`timescale 1ns/1ps
`include "homing_defs.vh"

module step_rate_gen (
	input wire core_clk,
	input wire rst_n,
	input wire ref_tick,
	input wire signed [11:0] vel,
	input wire [3:0] pulse_div,
	input wire [3:0] mres,
	output reg step_pulse_q,
	output reg step_dir_q,
	output reg fullstep_pulse_q
);

	// ---------------------------------------------
	// Microstep rate accumulator
	// ---------------------------------------------
	reg [30:0] acc_q;
	reg [8:0] micro_cnt_q;
	wire [3:0] pd_eff;
	wire [3:0] mres_eff;
	wire [30:0] thr;
	wire [10:0] vel_mag;
	wire [11:0] vel_neg;
	wire [30:0] acc_sum;

	assign pd_eff = (pulse_div > `DIV_MAX) ? `DIV_MAX : pulse_div;
	assign mres_eff = (mres > `MRES_MAX) ? `MRES_MAX : mres;
	assign thr = 31'h1 << (`VEL_SHIFT + pd_eff);
	assign vel_neg = -vel;
	assign vel_mag = vel[11] ? vel_neg[10:0] : vel[10:0];
	assign acc_sum = acc_q + {20'h0, vel_mag};

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 31'h0;
			step_pulse_q <= 1'b0;
			step_dir_q <= 1'b0;
		end else begin
			step_pulse_q <= 1'b0;
			step_dir_q <= ~vel[11];
			if (ref_tick) begin
				if (acc_sum >= thr) begin
					acc_q <= acc_sum - thr;
					step_pulse_q <= 1'b1;
				end else begin
					acc_q <= acc_sum;
				end
			end
		end
	end

	// ---------------------------------------------
	// Fullstep divider
	// ---------------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			micro_cnt_q <= 9'h0;
			fullstep_pulse_q <= 1'b0;
		end else begin
			fullstep_pulse_q <= 1'b0;
			if (step_pulse_q) begin
				if (micro_cnt_q >= (9'h1 << mres_eff) - 9'h1) begin
					micro_cnt_q <= 9'h0;
					fullstep_pulse_q <= 1'b1;
				end else begin
					micro_cnt_q <= micro_cnt_q + 9'h1;
				end
			end
		end
	end

endmodule

/* rtl/accel_ramp.v */
`timescale 1ns/1ps
`include "homing_defs.vh"

module accel_ramp (
	input wire core_clk,
	input wire rst_n,
	input wire ref_tick,
	input wire signed [11:0] target,
	input wire [10:0] accel,
	input wire [3:0] ramp_div,
	input wire [3:0] pulse_div,
	input wire pos_mode,
	output reg signed [11:0] vel_q
);

	// ---------------------------------------------
	// Usable acceleration window for positioning
	// ---------------------------------------------
	function [10:0] clamp_acc;
		input [10:0] a;
		input [3:0] rd;
		input [3:0] pd;
		reg signed [5:0] diff;
		reg [11:0] lo;
		reg [11:0] hi;
		begin
			diff = $signed({2'b00, rd}) - $signed({2'b00, pd});
			lo = (diff >= 6'sd1) ? (12'h1 << (diff - 6'sd1)) : 12'h0;
			if (diff + 6'sd12 >= 6'sd11)
				hi = {1'b0, `ACC_MAX};
			else if (diff + 6'sd12 <= 6'sd0)
				hi = 12'h0;
			else
				hi = (12'h1 << (diff + 6'sd12)) - 12'h1;
			if ({1'b0, a} < lo)
				clamp_acc = lo[10:0];
			else if ({1'b0, a} > hi)
				clamp_acc = hi[10:0];
			else
				clamp_acc = a;
		end
	endfunction

	// ---------------------------------------------
	// Velocity ramp
	// ---------------------------------------------
	reg [27:0] acc_q;
	wire [3:0] rd_eff;
	wire [3:0] pd_eff;
	wire [10:0] a_eff;
	wire [27:0] thr;
	wire [27:0] acc_sum;

	assign rd_eff = (ramp_div > `DIV_MAX) ? `DIV_MAX : ramp_div;
	assign pd_eff = (pulse_div > `DIV_MAX) ? `DIV_MAX : pulse_div;
	assign a_eff = pos_mode ? clamp_acc(accel, rd_eff, pd_eff) : accel;
	assign thr = 28'h1 << (`ACC_SHIFT + rd_eff);
	assign acc_sum = acc_q + {17'h0, a_eff};

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 28'h0;
			vel_q <= 12'sh0;
		end else if (vel_q == target) begin
			acc_q <= 28'h0;
		end else if (ref_tick) begin
			if (acc_sum >= thr) begin
				acc_q <= acc_sum - thr;
				vel_q <= (vel_q < target) ? vel_q + 12'sh1 : vel_q - 12'sh1;
			end else begin
				acc_q <= acc_sum;
			end
		end
	end

endmodule

/* verification/reference_search_homing_assertions.sv */
`timescale 1ns/1ps

module homing_checker (
	input wire core_clk,
	input wire rst_n,
	input wire cmd_valid,
	input wire [7:0] cmd_opcode,
	input wire [1:0] cmd_type,
	input wire rsp_valid_q,
	input wire rsp_error_q,
	input wire rsp_busy_q,
	input wire [7:0] homing_mode,
	input wire step_pulse,
	input wire step_dir,
	input wire fullstep_pulse,
	input wire signed [31:0] actual_position_q,
	input wire search_busy_q
);
	// ----------------------------------------
	// Command checks
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire take = cmd_valid && cmd_opcode == 8'h0d;
	wire good = homing_mode[5:0] != 6'h00 && homing_mode[5:0] <= 6'h08;
	wire start_idle = take && cmd_type == 2'h0 && !search_busy_q;
	property p_reply; take |=> rsp_valid_q; endproperty
	a_reply: assert property (p_reply) else $error("reply missing");
	property p_ignore; !take |=> !rsp_valid_q; endproperty
	a_ignore: assert property (p_ignore) else $error("reply without command");
	property p_type3; take && cmd_type == 2'h3 |=> rsp_error_q; endproperty
	a_type3: assert property (p_type3) else $error("bad type accepted");
	property p_good; start_idle && good |=> search_busy_q && rsp_busy_q && !rsp_error_q; endproperty
	a_good: assert property (p_good) else $error("valid start refused");
	property p_bad; start_idle && !good |=> rsp_error_q && !search_busy_q; endproperty
	a_bad: assert property (p_bad) else $error("invalid mode started");
	property p_status; take && cmd_type == 2'h2 && !search_busy_q |=> !rsp_busy_q; endproperty
	a_status: assert property (p_status) else $error("idle status shows busy");
	// ----------------------------------------
	// Step checks
	// ----------------------------------------
	sequence s_idle_step; step_pulse && !search_busy_q; endsequence
	sequence s_done; $fell(search_busy_q); endsequence
	property p_step_pos;
		s_idle_step |=> actual_position_q == $past(actual_position_q) +
			($past(step_dir) ? 32'sd1 : -32'sd1);
	endproperty
	a_step_pos: assert property (p_step_pos) else $error("position not stepped");
	property p_step_once; step_pulse |=> !step_pulse; endproperty
	a_step_once: assert property (p_step_once) else $error("step pulse too long");
	property p_full; fullstep_pulse |-> $past(step_pulse); endproperty
	a_full: assert property (p_full) else $error("fullstep without step");
	property p_halt; s_done |-> !step_pulse [*8]; endproperty
	a_halt: assert property (p_halt) else $error("motor moving after search");
endmodule

/* verification/axis_model.sv */
`timescale 1ns/1ps

module axis_model (
	input wire core_clk,
	input wire rst_n,
	input wire step_pulse,
	input wire step_dir,
	input wire home_inv,
	output wire left_sw_pin,
	output wire right_sw_pin,
	output wire home_sw_pin,
	output int pos
);
	// ----------------------------------------
	// Slider position and switch cams
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos <= 0;
		end else if (step_pulse === 1'b1) begin
			pos <= step_dir ? pos + 1 : pos - 1;
		end
	end
	assign left_sw_pin = pos >= -20 && pos <= -8;
	assign right_sw_pin = pos >= 8 && pos <= 20;
	assign home_sw_pin = (pos >= 4 && pos <= 7) ^ home_inv;
endmodule

/* verification/reference_search_homing_bench.sv */
`timescale 1ns/1ps

module reference_search_homing_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic core_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, pos_mode = 1'b0;
	logic stop_left_en = 1'b1, stop_right_en = 1'b1, home_inv = 1'b0;
	logic [7:0] cmd_opcode = 8'h00, homing_mode = 8'h01;
	logic [1:0] cmd_type = 2'h0;
	logic signed [11:0] host_velocity = 12'sh000;
	logic [10:0] search_speed = 11'h100, calib_speed = 11'h040, accel = 11'h7ff;
	logic [3:0] pulse_div = 4'h0, ramp_div = 4'h0, mres = 4'h2;
	wire rsp_valid_q, rsp_error_q, rsp_busy_q, left_sw_pin, right_sw_pin, home_sw_pin;
	wire step_pulse, step_dir, fullstep_pulse, search_busy_q;
	wire signed [31:0] actual_position_q;
	wire [31:0] switch_distance_q;
	int pos, error_cnt = 0, checks_done = 0, fcnt = 0, p0, f0, a0, n, r, v;
	logic [1:0] exp_q[$];
	logic [15:0] lfsr = 16'h63ea;
	logic [7:0] modes[12] = '{8'h01, 8'h41, 8'h42, 8'h02, 8'h43, 8'h03, 8'h04, 8'h44,
		8'h05, 8'h06, 8'h08, 8'h07};
	logic dirs[12] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1};

	always #20 core_clk = ~core_clk;

	reference_search_homing dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .cmd_type(cmd_type), .rsp_valid_q(rsp_valid_q),
		.rsp_error_q(rsp_error_q), .rsp_busy_q(rsp_busy_q), .homing_mode(homing_mode),
		.host_velocity(host_velocity), .search_speed(search_speed), .calib_speed(calib_speed),
		.accel(accel), .pulse_div(pulse_div), .ramp_div(ramp_div), .mres(mres),
		.pos_mode(pos_mode), .stop_left_en(stop_left_en), .stop_right_en(stop_right_en),
		.left_sw_pin(left_sw_pin), .right_sw_pin(right_sw_pin), .home_sw_pin(home_sw_pin),
		.step_pulse(step_pulse), .step_dir(step_dir), .fullstep_pulse(fullstep_pulse),
		.actual_position_q(actual_position_q), .switch_distance_q(switch_distance_q),
		.search_busy_q(search_busy_q));
	axis_model axis (.core_clk(core_clk), .rst_n(rst_n), .step_pulse(step_pulse),
		.step_dir(step_dir), .home_inv(home_inv), .left_sw_pin(left_sw_pin),
		.right_sw_pin(right_sw_pin), .home_sw_pin(home_sw_pin), .pos(pos));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task complete_run;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task send(input logic [1:0] t, input logic [7:0] m, input logic [1:0] e, input bit want);
		@(posedge core_clk);
		#2;
		homing_mode = m;
		cmd_type = t;
		cmd_opcode = want ? 8'h0d : 8'h0c;
		cmd_valid = 1'b1;
		if (want) exp_q.push_back(e);
		@(posedge core_clk);
		#2;
		cmd_valid = 1'b0;
	endtask

	task wait_idle(input int lim);
		n = 0;
		while (search_busy_q !== 1'b0 && n < lim) begin
			@(posedge core_clk);
			#2;
			n++;
		end
		if (n >= lim) begin
			error_cnt++;
			complete_run();
		end
	endtask

	task home(input logic [7:0] m, input logic [10:0] spd, input int lo, input int hi);
		search_speed = spd;
		send(2'h0, m, 2'h1, 1'b1);
		wait_idle(40000);
		r = pos - actual_position_q;
		chk(r >= lo && r <= hi, 1'b1, "reference point");
	endtask

	// ----------------------------------------
	// Reply monitor and fullstep counter
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (fullstep_pulse === 1'b1) fcnt++;
		if (rsp_valid_q === 1'b1) begin
			if (exp_q.size() == 0) chk(1'b1, 1'b0, "unexpected reply");
			else chk({rsp_error_q, rsp_busy_q}, exp_q.pop_front(), "reply");
		end
	end

	initial begin
		repeat (98000) @(posedge core_clk);
		error_cnt++;
		complete_run();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		#2;
		rst_n = 1'b1;
		send(2'h3, 8'h01, 2'h2, 1'b1);
		send(2'h2, 8'h01, 2'h0, 1'b0);
		send(2'h2, 8'h01, 2'h0, 1'b1);
		foreach (modes[i]) begin
			lfsr = lfsr_next(lfsr);
			send(2'h0, {lfsr[1:0], (i == 0) ? 6'h00 : 6'h08 + 6'(i * 4)}, 2'h2, 1'b1);
		end
		foreach (modes[i]) begin
			p0 = pos;
			send(2'h0, modes[i], 2'h1, 1'b1);
			send(2'h2, modes[i], 2'h1, 1'b1);
			n = 0;
			while (pos == p0 && n < 5000) begin
				@(posedge core_clk);
				#2;
				n++;
			end
			chk(pos - p0, dirs[i] ? 32'sd1 : -32'sd1, "search direction");
			send(2'h1, modes[i], 2'h1, 1'b1);
			wait_idle(20000);
		end
		home_inv = 1'b1;
		home(8'h87, 11'h0c0, 3, 8);
		home(8'h42, 11'h100, 6, 10);
		chk(switch_distance_q >= 13 && switch_distance_q <= 19, 1'b1, "distance");
		stop_left_en = 1'b0;
		stop_right_en = 1'b0;
		mres = 4'h3;
		lfsr = lfsr_next(lfsr);
		v = 512 + lfsr[8:0];
		host_velocity = -v;
		repeat (7000) @(posedge core_clk);
		#2;
		p0 = pos;
		f0 = fcnt;
		a0 = actual_position_q;
		repeat (6400) @(posedge core_clk);
		#2;
		chk(p0 - pos >= v / 16 - 1 && p0 - pos <= v / 16 + 1, 1'b1, "step rate");
		chk(fcnt - f0 >= v / 128 - 1 && fcnt - f0 <= v / 128 + 1, 1'b1, "fullsteps");
		chk(a0 - actual_position_q, p0 - pos, "position count");
		chk(exp_q.size(), 0, "pending replies");
		complete_run();
	end
endmodule

bind reference_search_homing homing_checker chk_i (.core_clk, .rst_n, .cmd_valid, .cmd_opcode,
	.cmd_type, .rsp_valid_q, .rsp_error_q, .rsp_busy_q, .homing_mode, .step_pulse, .step_dir,
	.fullstep_pulse, .actual_position_q, .search_busy_q);
